// [src/usb_rx_ep_regs.svh]
/*
  Offsets, field positions, reset values and limits for the endpoint
  receive status and control registers.
  Assumes inclusion by bare name from the controller and bench files.
*/
`ifndef USB_RX_EP_REGS_SVH
`define USB_RX_EP_REGS_SVH

`define RX_STATUS_ADDR     32'h5000186C
`define RX_CONTROL_ADDR    32'h5000186E
`define RX_STATUS_RESET    16'h0000
`define RX_CONTROL_RESET   16'h0000
`define RXS_ERR_BIT        7
`define RXS_SETUP_BIT      6
`define RXS_TOGGLE_BIT     5
`define RXS_LAST_BIT       4
`define RXC_WARN_HI_BIT    6
`define RXC_WARN_LO_BIT    5
`define RXC_FLUSH_BIT      3
`define RXC_IGN_SETUP_BIT  2
`define RXC_WRITE_MASK     16'h006C
`define WARN_LIMIT_1       6'h05
`define WARN_LIMIT_2       6'h09
`define WARN_LIMIT_3       6'h11
`define COUNT_SATURATE     4'hF
`define FIFO_DEPTH_DEFAULT 16
`define FIFO_WIDTH_DEFAULT 8

`endif

// [src/usb_rx_ep_pkg.sv]
/*
  Types shared by the receive endpoint logic.
  Uses nothing from the register header.
*/
package usb_rx_ep_pkg;

  // Receive state of the endpoint
  typedef enum logic [1:0]
  {
    RX_IDLE,
    RX_DATA,
    RX_SETUP
  } rx_state_t;

  // Event strobes from the link layer, one cycle each
  typedef struct packed
  {
    logic       setup_token;   // SETUP token for this endpoint
    logic       out_token;     // OUT token for this endpoint
    logic       pkt_end_ok;    // Packet ended with good CRC
    logic       pkt_end_err;   // Packet ended with media error
    logic       data1_pid;     // Data PID of the packet was DATA1
    logic       ack_sent;      // ACK handshake went out
  } link_event_t;

  // Core bus access
  typedef struct packed
  {
    logic        rd;           // Read strobe
    logic        wr;           // Write strobe
    logic [31:0] addr;         // Byte address
    logic [15:0] wdata;        // Write data
  } core_req_t;

endpackage

// [src/rx_byte_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides and a synchronous
  clear that resets both pointers.
  Assumes one clock and a synchronous active-high reset.
*/
module rx_byte_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     clear_i,
  input  wire logic [WIDTH-1:0]         in_data_i,
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  output logic [WIDTH-1:0]              out_data_o,
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0]    level_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];     // Storage array
  logic [AW-1:0]    wptr_q, wptr_d;    // Write pointer
  logic [AW-1:0]    rptr_q, rptr_d;    // Read pointer
  logic [LW-1:0]    lvl_q, lvl_d;      // Occupancy
  logic             push, pop;

  // Handshakes are combinational from the level
  assign in_ready_o  = (lvl_q != LW'(DEPTH));
  assign out_valid_o = (lvl_q != '0);
  assign out_data_o  = mem_q[rptr_q];
  assign level_o     = lvl_q;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and level update; clear drops everything
  always_comb
  begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    lvl_d  = lvl_q;
    if (clear_i)
    begin
      wptr_d = '0;
      rptr_d = '0;
      lvl_d  = '0;
    end
    else
    begin
      if (push)
        wptr_d = (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + AW'(1);
      if (pop)
        rptr_d = (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + AW'(1);
      lvl_d = lvl_q + LW'(push) - LW'(pop);
    end
  end

  // Pointer registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      lvl_q  <= '0;
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      lvl_q  <= lvl_d;
    end
  end

  // Storage has no reset, write only on push
  always_ff @(posedge clk_i)
  begin
    if (push && !clear_i)
      mem_q[wptr_q] <= in_data_i;
  end

  chk_no_overflow: assert property (@(posedge clk_i) disable iff (srst_i)
    lvl_q <= LW'(DEPTH))
    else $error("fifo level above depth");

endmodule

// [src/usb_rx_ep_ctrl.sv]
/*
  Receive status and control for one full-speed USB endpoint: status
  flags, saturating byte count, warning limit, deferred flush, SETUP
  ignore, and the receive FIFO between link and core bus.
  Assumes the link layer gives one-cycle event strobes on clk_i and
  that the core bus reads data through the FIFO drain port.
*/
// Function
// - Set error flag on media error
// - Setup flag set on SETUP, read clears
// - Non-iso toggle shows last data PID
// - Iso toggle captures frame number LSB
// - Status read clears toggle flag
// - Last flag set on ACK, read clears
// - Count field saturates at fifteen bytes
// - Warn when free space at or below limit
// - Limit codes off, 5, 9, 17 bytes
// - Flush clears FIFO, pointers and state
// - Flush waits for reception to finish
// - Ignore SETUP tokens when bit set
// - Iso bit selects toggle meaning
`include "usb_rx_ep_regs.svh"

module usb_rx_ep_ctrl
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT,
  parameter int FIFO_WIDTH = `FIFO_WIDTH_DEFAULT
)
(
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  input  wire usb_rx_ep_pkg::core_req_t    core_req_i,
  output logic [15:0]                      core_rdata_o,
  input  wire usb_rx_ep_pkg::link_event_t  link_ev_i,
  input  wire logic [FIFO_WIDTH-1:0]       link_data_i,
  input  wire logic                        link_valid_i,
  output logic                             link_ready_o,
  input  wire logic                        iso_mode_i,
  input  wire logic                        frame_number_lsb_i,
  output logic [FIFO_WIDTH-1:0]            rx_data_o,
  output logic                             rx_valid_o,
  input  wire logic                        rx_ready_i,
  output logic                             receive_warning_event_o,
  output logic                             setup_accept_o,
  output logic                             busy_o
);
  import usb_rx_ep_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH+1);

  rx_state_t   state_q, state_d;        // Receive state
  logic        err_q, err_d;            // Media error flag
  logic        setup_q, setup_d;        // SETUP received flag
  logic        toggle_q, toggle_d;      // Toggle or frame LSB
  logic        last_q, last_d;          // ACK sent flag
  logic [1:0]  warn_lim_q, warn_lim_d;  // Warning limit code
  logic        ign_q, ign_d;            // Ignore SETUP tokens
  logic        flush_q, flush_d;        // Pending flush request
  logic        warn_q, warn_d;          // Registered warning level
  logic [15:0] rdata_q, rdata_d;        // Read data register
  logic        fifo_clear;              // Flush strobe into FIFO
  logic [LW-1:0] level;                 // FIFO occupancy
  logic [LW-1:0] free_bytes;            // Empty locations
  logic        st_rd, ct_wr, ct_rd;
  logic        setup_ok;
  logic        receiving;

  // Threshold decode, used for warning and its check
  function automatic logic [5:0] limit_of(input logic [1:0] code);
    unique case (code)
      2'h0: limit_of = 6'h00;
      2'h1: limit_of = `WARN_LIMIT_1;
      2'h2: limit_of = `WARN_LIMIT_2;
      2'h3: limit_of = `WARN_LIMIT_3;
    endcase
  endfunction

  // Address decode of the two registers
  assign st_rd = core_req_i.rd && (core_req_i.addr == `RX_STATUS_ADDR);
  assign ct_rd = core_req_i.rd && (core_req_i.addr == `RX_CONTROL_ADDR);
  assign ct_wr = core_req_i.wr && (core_req_i.addr == `RX_CONTROL_ADDR);

  // SETUP accepted only when not ignored
  assign setup_ok       = link_ev_i.setup_token && !ign_q;
  assign setup_accept_o = setup_ok;
  assign receiving      = (state_q != RX_IDLE);
  assign busy_o         = receiving;
  assign free_bytes     = LW'(FIFO_DEPTH) - level;
  assign receive_warning_event_o = warn_q;
  assign core_rdata_o   = rdata_q;

  // Flush only between packets; a pending one waits here
  assign fifo_clear = flush_q && !receiving && !link_ev_i.out_token
                      && !setup_ok;

  // Receive FIFO; back-pressure reaches the link through ready
  rx_byte_fifo
  #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .clear_i     (fifo_clear),
    .in_data_i   (link_data_i),
    .in_valid_i  (link_valid_i && receiving),
    .in_ready_o  (link_ready_o),
    .out_data_o  (rx_data_o),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .level_o     (level)
  );

  // Receive state: idle until a token, back at packet end
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RX_IDLE:
      begin
        if (setup_ok)
          state_d = RX_SETUP;
        else if (link_ev_i.out_token)
          state_d = RX_DATA;
      end
      RX_DATA, RX_SETUP:
      begin
        // Packet end of either kind returns to idle
        if (link_ev_i.pkt_end_ok || link_ev_i.pkt_end_err)
          state_d = RX_IDLE;
      end
      default: state_d = RX_IDLE;
    endcase
  end

  // Status flags: hardware set wins over read clear
  always_comb
  begin
    err_d    = err_q;
    setup_d  = setup_q;
    toggle_d = toggle_q;
    last_d   = last_q;
    if (st_rd)
    begin
      setup_d  = 1'b0;
      toggle_d = 1'b0;
      last_d   = 1'b0;
    end
    // Error flag clears only by flush, so firmware must flush
    if (fifo_clear)
      err_d = 1'b0;
    if (receiving && link_ev_i.pkt_end_err)
      err_d = 1'b1;
    if (setup_ok)
      setup_d = 1'b1;
    if (receiving && link_ev_i.pkt_end_ok)
    begin
      // Iso bit picks frame LSB over data PID
      if (iso_mode_i)
        toggle_d = frame_number_lsb_i;
      else
        toggle_d = link_ev_i.data1_pid;
    end
    if (link_ev_i.ack_sent)
      last_d = 1'b1;
  end

  // Control register; write mask drops reserved bits
  always_comb
  begin
    warn_lim_d = warn_lim_q;
    ign_d      = ign_q;
    flush_d    = flush_q;
    if (fifo_clear)
      flush_d = 1'b0;
    if (ct_wr)
    begin
      warn_lim_d = core_req_i.wdata[`RXC_WARN_HI_BIT:`RXC_WARN_LO_BIT];
      ign_d      = core_req_i.wdata[`RXC_IGN_SETUP_BIT];
      if (core_req_i.wdata[`RXC_FLUSH_BIT])
        flush_d = 1'b1;
    end
  end

  // Warning level: free space at or below limit
  always_comb
  begin
    warn_d = (warn_lim_q != 2'h0)
             && (6'(free_bytes) <= limit_of(warn_lim_q));
  end

  // Read data mux; reserved bits are zero
  always_comb
  begin
    rdata_d = 16'h0000;
    if (st_rd)
    begin
      rdata_d[`RXS_ERR_BIT]    = err_q;
      rdata_d[`RXS_SETUP_BIT]  = setup_q;
      rdata_d[`RXS_TOGGLE_BIT] = toggle_q;
      rdata_d[`RXS_LAST_BIT]   = last_q;
      // Count saturates rather than wrapping
      rdata_d[3:0] = (level > LW'(`COUNT_SATURATE)) ? `COUNT_SATURATE
                                                     : 4'(level);
    end
    else if (ct_rd)
    begin
      rdata_d = `RX_CONTROL_RESET;
      rdata_d[`RXC_WARN_HI_BIT:`RXC_WARN_LO_BIT] = warn_lim_q;
      rdata_d[`RXC_FLUSH_BIT]     = flush_q;
      rdata_d[`RXC_IGN_SETUP_BIT] = ign_q;
      rdata_d = rdata_d & `RXC_WRITE_MASK;
    end
  end

  // All registers of the block
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q    <= RX_IDLE;
      err_q      <= 1'b0;
      setup_q    <= 1'b0;
      toggle_q   <= 1'b0;
      last_q     <= 1'b0;
      warn_lim_q <= 2'h0;
      ign_q      <= 1'b0;
      flush_q    <= 1'b0;
      warn_q     <= 1'b0;
      rdata_q    <= `RX_STATUS_RESET;
    end
    else
    begin
      // Flush also forces the state to idle
      state_q    <= fifo_clear ? RX_IDLE : state_d;
      err_q      <= err_d;
      setup_q    <= setup_d;
      toggle_q   <= toggle_d;
      last_q     <= last_d;
      warn_lim_q <= warn_lim_d;
      ign_q      <= ign_d;
      flush_q    <= flush_d;
      warn_q     <= warn_d;
      rdata_q    <= rdata_d;
    end
  end

  chk_err_sets: assert property (@(posedge clk_i) disable iff (srst_i)
    receiving && link_ev_i.pkt_end_err |=> err_q)
    else $error("error flag not set");

  chk_setup_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    setup_ok |=> setup_q)
    else $error("setup flag not set");

  chk_setup_read: assert property (@(posedge clk_i) disable iff (srst_i)
    st_rd && !setup_ok |=> !setup_q)
    else $error("setup flag survives read");

  chk_toggle_pid: assert property (@(posedge clk_i) disable iff (srst_i)
    receiving && link_ev_i.pkt_end_ok && !iso_mode_i
    |=> toggle_q == $past(link_ev_i.data1_pid))
    else $error("toggle not data pid");

  chk_toggle_iso: assert property (@(posedge clk_i) disable iff (srst_i)
    receiving && link_ev_i.pkt_end_ok && iso_mode_i
    |=> toggle_q == $past(frame_number_lsb_i))
    else $error("toggle not frame lsb");

  chk_toggle_read: assert property (@(posedge clk_i) disable iff (srst_i)
    st_rd && !(receiving && link_ev_i.pkt_end_ok) |=> !toggle_q)
    else $error("toggle survives read");

  chk_last_ack: assert property (@(posedge clk_i) disable iff (srst_i)
    link_ev_i.ack_sent |=> last_q ##1 (last_q || $past(st_rd)))
    else $error("last flag not set on ack");

  chk_count_sat: assert property (@(posedge clk_i) disable iff (srst_i)
    st_rd |=> core_rdata_o[3:0] == (($past(level) > LW'(15)) ? 4'hF
                                     : 4'($past(level))))
    else $error("count field wrong");

  chk_warn_level: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 warn_q == ($past(warn_lim_q) != 2'h0
      && 6'($past(free_bytes)) <= limit_of($past(warn_lim_q))))
    else $error("warning level wrong");

  // Watches the FIFO itself: no byte may vanish mid-packet except by a pop
  chk_flush_defer: assert property (@(posedge clk_i) disable iff (srst_i)
    receiving && !(rx_valid_o && rx_ready_i) |=> level >= $past(level))
    else $error("flush during reception");

  chk_flush_done: assert property (@(posedge clk_i) disable iff (srst_i)
    fifo_clear |=> level == '0 && state_q == RX_IDLE && !flush_q)
    else $error("flush incomplete");

  chk_ign_setup: assert property (@(posedge clk_i) disable iff (srst_i)
    ign_q && link_ev_i.setup_token && state_q == RX_IDLE
    |=> state_q != RX_SETUP)
    else $error("setup not ignored");

  chk_reserved: assert property (@(posedge clk_i) disable iff (srst_i)
    core_rdata_o[15:8] == 8'h00)
    else $error("reserved bits nonzero");

endmodule

// [tb/usb_host_link_model.sv]
/*
  Host end of the endpoint link: token, payload bytes, end and ACK strobes.
  Assumes the bench calls send() and drives nothing of the link itself.
*/
module usb_host_link_model
(
  input  wire logic                   clk_i,
  input  wire logic                   ready_i,
  input  wire logic                   setup_accept_i,
  output usb_rx_ep_pkg::link_event_t  ev_o,
  output logic [7:0]                  data_o,
  output logic                        valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import usb_rx_ep_pkg::*;

  logic       accepted;     // Acceptance seen with the last token
  logic [7:0] sent_q [$];   // Bytes offered while ready was high, in order

  // Quiet link at time zero
  initial
  begin
    ev_o = '0;
    data_o = 8'h00;
    valid_o = 1'b0;
    accepted = 1'b0;
  end

  // One packet; gap sets how slowly bytes follow each other
  task automatic send(input bit setup, input int n, input bit d1, input bit err, input bit ack, input int gap);
    link_event_t e;
    @(posedge clk_i);
    e = '0;
    e.setup_token = setup;
    // Every OUT token assumes firmware has re-armed reception
    e.out_token = !setup;
    ev_o <= e;
    @(posedge clk_i);
    accepted = setup_accept_i;
    ev_o <= '0;
    for (int i = 0; i < n; i++)
    begin
      data_o <= 8'($urandom);
      valid_o <= 1'b1;
      do @(posedge clk_i); while (!ready_i);
      sent_q.push_back(data_o);
      // Released line shows the inverse, never a stale byte
      if (gap > 0 || i == n - 1)
      begin
        valid_o <= 1'b0;
        data_o <= ~data_o;
        repeat (gap) @(posedge clk_i);
      end
    end
    @(posedge clk_i);
    e = '0;
    e.pkt_end_ok = !err;
    e.pkt_end_err = err;
    e.data1_pid = d1;
    ev_o <= e;
    @(posedge clk_i);
    e = '0;
    e.ack_sent = ack && !err;   // No handshake after a damaged packet
    ev_o <= e;
    @(posedge clk_i);
    ev_o <= '0;
    @(posedge clk_i);
  endtask
endmodule

// [tb/tb_usb_rx_ep_ctrl.sv]
/*
  Self-checking bench for the endpoint receive status and control logic.
  Assumes the design sources, the package and the host link model.
*/
`include "usb_rx_ep_regs.svh"

module tb_usb_rx_ep_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import usb_rx_ep_pkg::*;

  localparam int LIM [4] = '{0, 5, 9, 17};  // Free bytes that warn, per code
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  core_req_t   req = '0;
  logic [15:0] rdata;
  link_event_t ev;
  logic [7:0]  ldata;
  logic [7:0]  rx_data;
  logic        lvalid;
  logic        lready;
  logic        iso = 1'b0;
  logic        fnl = 1'b0;
  logic        rx_valid;
  logic        rx_ready = 1'b0;
  logic        warn;
  logic        sacc;
  logic        busy;
  logic        drain_en = 1'b0;   // Core side starts stalled
  logic [15:0] s;
  logic [7:0]  got_q [$];         // Bytes drained from the FIFO
  int          n_errors = 0;
  int          checks_done = 0;
  int          n;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  usb_rx_ep_ctrl u_usb_rx_ep_ctrl (.clk_i(clk_i), .srst_i(srst_i), .core_req_i(req), .core_rdata_o(rdata),
    .link_ev_i(ev), .link_data_i(ldata), .link_valid_i(lvalid), .link_ready_o(lready), .iso_mode_i(iso),
    .frame_number_lsb_i(fnl), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .receive_warning_event_o(warn), .setup_accept_o(sacc), .busy_o(busy));

  usb_host_link_model u_usb_host_link_model (.clk_i(clk_i), .ready_i(lready), .setup_accept_i(sacc),
    .ev_o(ev), .data_o(ldata), .valid_o(lvalid));

  // Drain side, stalling at random
  always @(posedge clk_i)
  begin
    if (rx_valid && rx_ready)
      got_q.push_back(rx_data);
    rx_ready <= drain_en && 1'($urandom);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Expected status word
  function automatic logic [15:0] st(input bit e, input bit su, input bit t, input bit l, input int c);
    return {8'h00, e, su, t, l, (c > 15) ? `COUNT_SATURATE : 4'(c)};
  endfunction

  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge clk_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask

  // Flush with other control bits; the model forgets dropped bytes
  task automatic flush(input logic [15:0] d);
    wr(`RX_CONTROL_ADDR, d | 16'h0008);
    repeat (3) @(posedge clk_i);
    u_usb_host_link_model.sent_q.delete();
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h66DA));
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`RX_STATUS_ADDR, s);
    chk(s, `RX_STATUS_RESET, "status reset");
    rd(`RX_CONTROL_ADDR, s);
    chk(s, `RX_CONTROL_RESET, "control reset");
    wr(`RX_CONTROL_ADDR, 16'hFFF7);
    wr(`RX_STATUS_ADDR, 16'hFFFF);
    rd(`RX_CONTROL_ADDR, s);
    chk(s, 16'h0064, "control mask");
    rd(32'h50001870, s);
    chk(s, 16'h0000, "unmapped");
    // Ignored SETUP leaves no trace
    u_usb_host_link_model.send(1'b1, 8, 1'b0, 1'b0, 1'b0, 0);
    chk(16'(u_usb_host_link_model.accepted), 16'h0000, "ignored setup");
    rd(`RX_STATUS_ADDR, s);
    chk(s, st(0, 0, 0, 0, 0), "ignored status");
    flush(16'h0000);
    // Toggle meaning in both modes, last flag, count
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      iso <= i[1];
      fnl <= !i[0];
      n = $urandom_range(4, 1);
      u_usb_host_link_model.send(1'b0, n, i[0], 1'b0, !i[1], $urandom_range(2, 0));
      n = u_usb_host_link_model.sent_q.size();
      rd(`RX_STATUS_ADDR, s);
      chk(s, st(0, 0, i[1] ? !i[0] : i[0], !i[1], n), "toggle");
      rd(`RX_STATUS_ADDR, s);
      chk(s, st(0, 0, 0, 0, n), "read clear");
    end
    // SETUP packet
    @(posedge clk_i);
    iso <= 1'b0;
    flush(16'h0000);
    u_usb_host_link_model.send(1'b1, 8, 1'b0, 1'b0, 1'b1, 0);
    chk(16'(u_usb_host_link_model.accepted), 16'h0001, "setup accept");
    rd(`RX_STATUS_ADDR, s);
    chk(s, st(0, 1, 0, 1, 8), "setup flag");
    rd(`RX_STATUS_ADDR, s);
    chk(s, st(0, 0, 0, 0, 8), "setup clear");
    // Media error survives a read
    flush(16'h0000);
    n = $urandom_range(6, 1);
    u_usb_host_link_model.send(1'b0, n, 1'b1, 1'b1, 1'b0, 1);
    rd(`RX_STATUS_ADDR, s);
    chk(s, st(1, 0, 0, 0, n), "error flag");
    rd(`RX_STATUS_ADDR, s);
    chk(s, st(1, 0, 0, 0, n), "error kept");
    flush(16'h0000);
    rd(`RX_STATUS_ADDR, s);
    chk(s, 16'h0000, "flushed");
    // Flush asked for mid-packet
    fork
      u_usb_host_link_model.send(1'b0, 6, 1'b0, 1'b0, 1'b1, 3);
      begin
        repeat (6) @(posedge clk_i);
        wr(`RX_CONTROL_ADDR, 16'h0008);
        rd(`RX_CONTROL_ADDR, s);
        chk(s, 16'h0008, "flush pending");
        rd(`RX_STATUS_ADDR, s);
        chk(16'(s[3:0] != 4'h0), 16'h0001, "bytes kept");
        chk(16'(busy), 16'h0001, "busy mid packet");
      end
    join
    u_usb_host_link_model.sent_q.delete();
    repeat (3) @(posedge clk_i);
    rd(`RX_CONTROL_ADDR, s);
    chk(s, 16'h0000, "flush done");
    rd(`RX_STATUS_ADDR, s);
    chk(16'(s[3:0]), 16'h0000, "late flush");
    chk(16'(busy), 16'h0000, "idle after flush");
    // Warning codes at and one above each limit; code 3 only at 16 free
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 2; k++)
      begin
        flush(16'(c) << 5);
        n = 16 - LIM[c] - k;
        if (n < 0)
          n = 0;
        u_usb_host_link_model.send(1'b0, n, 1'b0, 1'b0, 1'b1, 0);
        repeat (2) @(posedge clk_i);
        chk(16'(warn), 16'((c != 0) && (16 - n <= LIM[c])), "warning");
      end
    // Fill until refused, then drain while stalling
    flush(16'h0000);
    fork
      u_usb_host_link_model.send(1'b0, 20, 1'b1, 1'b0, 1'b1, 0);
      begin
        for (int w = 0; w < 200 && lready; w++)
          @(posedge clk_i);
        rd(`RX_STATUS_ADDR, s);
        chk(16'(s[3:0]), 16'h000F, "full count");
        drain_en = 1'b1;
      end
    join
    for (int w = 0; w < 200 && rx_valid; w++)
      @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    chk(16'(rx_valid), 16'h0000, "drained");
    rd(`RX_STATUS_ADDR, s);
    chk(s, st(0, 0, 1, 1, 0), "drained status");
    chk(16'(got_q.size()), 16'(u_usb_host_link_model.sent_q.size()), "byte total");
    foreach (got_q[j])
      chk(16'(got_q[j]), 16'(u_usb_host_link_model.sent_q[j]), "byte order");
    end_of_test();
  end

  // Watchdog; the run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_of_test();
  end
endmodule
